// ### verilog/sscr_pkg.sv
// Summary of operation
// - Upstream common-clock strap caught at fundamental reset, read-only at status bit 6.
// - Management slow-mode strap caught at fundamental reset, read-only at status bit 7.
// - Reference clock mode strap caught at fundamental reset, read-only at bit 8.
// - Reset-halt strap caught at fundamental reset, read-only at status bit 9.
// - Status bits 11:10 select base spec mode; only 0x1 defined, others reserved.
// - Status bits 22:20 report lock state: 0 unlocked, 2 to 5 locked port.
// - Status bits 31:28 are scratch, cleared by fundamental reset only, kept through hot reset.
// - Writing one to control bit 0 starts a fundamental reset.
// - Writing one to control bit 1 starts a hot reset.
// - Both trigger bits ignore zero writes and always read back zero.
// - Write-when-unlocked fields change only while the unlock control bit is set.
package sscr_pkg;

   // Register map, byte addresses on the bus
   localparam int unsigned SSCR_ADDR_W = 12;
   localparam logic [SSCR_ADDR_W-1:0] SSCR_STATUS_OFS  = 12'h400;
   localparam logic [SSCR_ADDR_W-1:0] SSCR_CONTROL_OFS = 12'h404;

   // Status field positions
   localparam int unsigned SSCR_STS_STRAP_LSB = 6;
   localparam int unsigned SSCR_STS_MODE_LSB  = 10;
   localparam int unsigned SSCR_STS_LOCK_LSB  = 20;
   localparam int unsigned SSCR_STS_MARK_LSB  = 28;

   // Control field positions
   localparam int unsigned SSCR_CTL_FUND_BIT   = 0;
   localparam int unsigned SSCR_CTL_HOT_BIT    = 1;
   localparam int unsigned SSCR_CTL_UNLOCK_BIT = 3;

   // Reset values
   localparam logic [1:0] SSCR_MODE_RST   = 2'h1;
   localparam logic [2:0] SSCR_LOCK_RST   = 3'h0;
   localparam logic [3:0] SSCR_MARK_RST   = 4'h0;
   localparam logic       SSCR_UNLOCK_RST = 1'b0;

   // Base spec mode codes
   localparam logic [1:0] SSCR_SPEC_REV_1_1_MODE = 2'h1;

   // Lock state codes
   localparam logic [2:0] SSCR_LOCK_UNLOCKED = 3'h0;
   localparam logic [2:0] SSCR_LOCK_PORT2    = 3'h2;
   localparam logic [2:0] SSCR_LOCK_PORT5    = 3'h5;

   // Strap capture window after reset release, covers the synchroniser depth
   localparam logic [1:0] SSCR_STRAP_CAP_CYC = 2'h3;

   // Bus responses
   localparam logic [1:0] SSCR_RESP_OKAY   = 2'h0;
   localparam logic [1:0] SSCR_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SSCR_REG_NONE,
      SSCR_REG_STATUS,
      SSCR_REG_CONTROL
   } sscr_reg_type;

endpackage : sscr_pkg

// ### verilog/sscr_reset_sync.sv
`timescale 1ns/1ps
module sscr_reset_sync (
   input  wire logic clock,
   input  wire logic rstn,
   output logic      rst_n_sync
);
   logic stage_r;

   // Asserts at once, releases after two edges
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         stage_r    <= 1'b0;
         rst_n_sync <= 1'b0;
      end
      else
      begin
         stage_r    <= 1'b1;
         rst_n_sync <= stage_r;
      end
   end
endmodule : sscr_reset_sync

// ### verilog/sscr_strap_capture.sv
`timescale 1ns/1ps
module sscr_strap_capture (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [3:0] strap_pins,
   input  wire logic       fund_reset_active,
   output logic [3:0]      strap_val
);
   import sscr_pkg::*;

   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   logic [1:0] cap_cnt_r;
   wire        capture;

   // Pins pass two flip-flops before anything reads them
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
      end
      else
      begin
         sync1_r <= strap_pins;
         sync2_r <= sync1_r;
      end
   end

   // Capture runs for a few cycles after release and during every fundamental reset
   assign capture = (cap_cnt_r != 2'h0) | fund_reset_active;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cap_cnt_r <= SSCR_STRAP_CAP_CYC;
         strap_val <= 4'h0;
      end
      else
      begin
         if (cap_cnt_r != 2'h0)
            cap_cnt_r <= cap_cnt_r - 2'h1;
         if (capture)
            strap_val <= sync2_r;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_strap_held: assert property (
      !capture |=> $stable(strap_val))
      else $error("Strap value changed outside a fundamental reset");
   a_strap_taken: assert property (
      capture |=> strap_val == $past(sync2_r))
      else $error("Strap value not taken from synchronised pins");
endmodule : sscr_strap_capture

// ### verilog/sscr_regs.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module sscr_regs (
   input  wire logic                             clock,
   input  wire logic                             rstn,
   // AXI4-Lite slave
   input  wire logic [sscr_pkg::SSCR_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]                       s_axi_awprot,
   input  wire logic                             s_axi_awvalid,
   output logic                                  s_axi_awready,
   input  wire logic [31:0]                      s_axi_wdata,
   input  wire logic [3:0]                       s_axi_wstrb,
   input  wire logic                             s_axi_wvalid,
   output logic                                  s_axi_wready,
   output logic [1:0]                            s_axi_bresp,
   output logic                                  s_axi_bvalid,
   input  wire logic                             s_axi_bready,
   input  wire logic [sscr_pkg::SSCR_ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]                       s_axi_arprot,
   input  wire logic                             s_axi_arvalid,
   output logic                                  s_axi_arready,
   output logic [31:0]                           s_axi_rdata,
   output logic [1:0]                            s_axi_rresp,
   output logic                                  s_axi_rvalid,
   input  wire logic                             s_axi_rready,
   // Strap pins
   input  wire logic                             upstream_common_clock_strap,
   input  wire logic                             master_mgmt_slow_strap,
   input  wire logic                             refclk_mode_strap,
   input  wire logic                             reset_halt_strap,
   // Reset sequencer and lock tracker
   input  wire logic                             fund_reset_active,
   input  wire logic [2:0]                       upstream_lock_state,
   output logic                                  fundamental_reset_trigger,
   output logic                                  hot_reset_trigger,
   output logic [1:0]                            base_spec_mode,
   output logic                                  register_write_unlock
);
   import sscr_pkg::*;

   logic                   rst_n;
   logic [3:0]             strap_val;
   logic                   aw_held_r;
   logic                   w_held_r;
   logic [SSCR_ADDR_W-1:0] awaddr_r;
   logic [31:0]            wdata_r;
   logic [3:0]             wstrb_r;
   logic [2:0]             lock_r;
   logic [3:0]             marker_r;

   // Register address decode, shared by reads and writes
   function automatic sscr_reg_type sscr_decode(input logic [SSCR_ADDR_W-1:0] addr);
      case (addr)
         SSCR_STATUS_OFS:  sscr_decode = SSCR_REG_STATUS;
         SSCR_CONTROL_OFS: sscr_decode = SSCR_REG_CONTROL;
         default:          sscr_decode = SSCR_REG_NONE;
      endcase
   endfunction : sscr_decode

   sscr_reset_sync u_reset_sync (
      .clock      (clock),
      .rstn       (rstn),
      .rst_n_sync (rst_n)
   );

   sscr_strap_capture u_strap_capture (
      .clock             (clock),
      .rst_n             (rst_n),
      .strap_pins        ({reset_halt_strap, refclk_mode_strap,
                           master_mgmt_slow_strap, upstream_common_clock_strap}),
      .fund_reset_active (fund_reset_active),
      .strap_val         (strap_val)
   );

   // Write channel handshakes; address and data may come in either order
   wire          aw_take  = s_axi_awvalid & s_axi_awready;
   wire          w_take   = s_axi_wvalid & s_axi_wready;
   wire          do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
   wire          aw_nxt   = aw_held_r ? ~do_write : aw_take;
   wire          w_nxt    = w_held_r ? ~do_write : w_take;
   wire          bv_nxt   = do_write | (s_axi_bvalid & ~s_axi_bready);
   wire sscr_reg_type wr_sel = sscr_decode(awaddr_r);

   // Read channel handshake
   wire          ar_take  = s_axi_arvalid & s_axi_arready;
   wire          rv_nxt   = ar_take | (s_axi_rvalid & ~s_axi_rready);
   wire sscr_reg_type rd_sel = sscr_decode(s_axi_araddr);

   // Write enables per field
   wire          wr_status  = do_write & (wr_sel == SSCR_REG_STATUS);
   wire          wr_control = do_write & (wr_sel == SSCR_REG_CONTROL);
   wire          mode_we    = wr_status & wstrb_r[1] & register_write_unlock;
   wire          marker_we  = wr_status & wstrb_r[3];
   wire          ctl_we     = wr_control & wstrb_r[0];
   wire          fund_req   = ctl_we & wdata_r[SSCR_CTL_FUND_BIT];
   wire          hot_req    = ctl_we & wdata_r[SSCR_CTL_HOT_BIT];

   // Read views; reserved and trigger bits return zero
   wire [31:0]   status_word  = {marker_r, 5'h00, lock_r, 8'h00,
                                 base_spec_mode, strap_val, 6'h00};
   wire [31:0]   control_word = {28'h0000000, register_write_unlock, 3'h0};
   wire [31:0]   rd_word = (rd_sel == SSCR_REG_STATUS)  ? status_word :
                           (rd_sel == SSCR_REG_CONTROL) ? control_word : 32'h00000000;
   wire [1:0]    rd_resp = (rd_sel == SSCR_REG_NONE) ? SSCR_RESP_SLVERR : SSCR_RESP_OKAY;
   wire [1:0]    wr_resp = (wr_sel == SSCR_REG_NONE) ? SSCR_RESP_SLVERR : SSCR_RESP_OKAY;

   // Write address and data holding
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held_r     <= 1'b0;
         w_held_r      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         awaddr_r      <= '0;
         wdata_r       <= 32'h00000000;
         wstrb_r       <= 4'h0;
      end
      else
      begin
         aw_held_r     <= aw_nxt;
         w_held_r      <= w_nxt;
         s_axi_awready <= ~aw_nxt & ~bv_nxt;
         s_axi_wready  <= ~w_nxt & ~bv_nxt;
         if (aw_take)
            awaddr_r <= s_axi_awaddr;
         if (w_take)
         begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
      end
   end

   // Write response and read answer
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= SSCR_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= SSCR_RESP_OKAY;
      end
      else
      begin
         s_axi_bvalid  <= bv_nxt;
         s_axi_arready <= ~rv_nxt;
         s_axi_rvalid  <= rv_nxt;
         if (do_write)
            s_axi_bresp <= wr_resp;
         if (ar_take)
         begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_resp;
         end
      end
   end

   // Software-held fields; a fundamental reset outranks any write
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         base_spec_mode        <= SSCR_MODE_RST;
         marker_r              <= SSCR_MARK_RST;
         register_write_unlock <= SSCR_UNLOCK_RST;
      end
      else if (fund_reset_active)
      begin
         base_spec_mode        <= SSCR_MODE_RST;
         marker_r              <= SSCR_MARK_RST;
         register_write_unlock <= SSCR_UNLOCK_RST;
      end
      else
      begin
         if (mode_we)
            base_spec_mode <= wdata_r[SSCR_STS_MODE_LSB +: 2];
         if (marker_we)
            marker_r <= wdata_r[SSCR_STS_MARK_LSB +: 4];
         if (ctl_we)
            register_write_unlock <= wdata_r[SSCR_CTL_UNLOCK_BIT];
      end
   end

   // Lock state sampled from the tracker, trigger pulses toward the sequencer
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lock_r                    <= SSCR_LOCK_RST;
         fundamental_reset_trigger <= 1'b0;
         hot_reset_trigger         <= 1'b0;
      end
      else
      begin
         lock_r                    <= upstream_lock_state;
         fundamental_reset_trigger <= fund_req;
         hot_reset_trigger         <= hot_req;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_read_straps: assert property (
      ar_take && rd_sel == SSCR_REG_STATUS
      |=> s_axi_rdata[SSCR_STS_STRAP_LSB +: 4] == $past(strap_val))
      else $error("Status read shows wrong strap bits");
   a_mode_write: assert property (
      mode_we && !fund_reset_active
      |=> base_spec_mode == $past(wdata_r[SSCR_STS_MODE_LSB +: 2]))
      else $error("Unlocked mode write not stored");
   a_mode_locked: assert property (
      !$stable(base_spec_mode) |-> $past(register_write_unlock) || $past(fund_reset_active))
      else $error("Mode changed while registers locked");
   a_lock_report: assert property (
      ar_take && rd_sel == SSCR_REG_STATUS
      |=> s_axi_rdata[SSCR_STS_LOCK_LSB +: 3] == $past(upstream_lock_state, 2))
      else $error("Lock state not reported");
   a_marker_keep: assert property (
      !$stable(marker_r) |-> $past(marker_we) || $past(fund_reset_active))
      else $error("Scratch field changed without write or fundamental reset");
   a_fund_pulse: assert property (
      fund_req |=> fundamental_reset_trigger ##1 !fundamental_reset_trigger)
      else $error("Fundamental reset trigger not a single pulse");
   a_hot_pulse: assert property (
      hot_req |=> hot_reset_trigger ##1 !hot_reset_trigger)
      else $error("Hot reset trigger not a single pulse");
   a_trig_cause: assert property (
      fundamental_reset_trigger || hot_reset_trigger
      |-> $past(ctl_we) && ($past(wdata_r[1:0]) != 2'h0))
      else $error("Trigger fired without a written one");
   a_ctl_readzero: assert property (
      ar_take && rd_sel == SSCR_REG_CONTROL |=> s_axi_rdata[1:0] == 2'h0)
      else $error("Trigger bits read nonzero");
   a_rsvd_zero: assert property (
      ar_take && rd_sel == SSCR_REG_STATUS
      |=> s_axi_rdata[19:12] == 8'h00 && s_axi_rdata[27:23] == 5'h00)
      else $error("Reserved status bits read nonzero");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped before taken");

   // Software fields around a fundamental reset and the unlock bit, then locked port reporting
   a_mode_fund: assert property (
      fund_reset_active
      |=> base_spec_mode == SSCR_SPEC_REV_1_1_MODE)
      else $error("Mode not back to default after fundamental reset");
   a_mode_hold: assert property (
      wr_status && !register_write_unlock && !fund_reset_active
      |=> $stable(base_spec_mode))
      else $error("Locked mode field took a write");
   a_marker_fund: assert property (
      fund_reset_active
      |=> marker_r == SSCR_MARK_RST)
      else $error("Scratch field not cleared by fundamental reset");
   a_marker_write: assert property (
      marker_we && !fund_reset_active
      |=> marker_r == $past(wdata_r[SSCR_STS_MARK_LSB +: 4]))
      else $error("Scratch write not stored");
   a_unlock_fund: assert property (
      fund_reset_active
      |=> !register_write_unlock)
      else $error("Unlock bit survived a fundamental reset");
   a_lock_locked: assert property (
      ar_take && rd_sel == SSCR_REG_STATUS && lock_r >= SSCR_LOCK_PORT2 && lock_r <= SSCR_LOCK_PORT5
      |=> s_axi_rdata[SSCR_STS_LOCK_LSB +: 3] == $past(lock_r))
      else $error("Locked port code not reported");

   // Zero writes leave the triggers quiet
   a_fund_quiet: assert property (
      ctl_we && !wdata_r[SSCR_CTL_FUND_BIT]
      |=> !fundamental_reset_trigger)
      else $error("Fundamental trigger fired on a zero write");
   a_hot_quiet: assert property (
      ctl_we && !wdata_r[SSCR_CTL_HOT_BIT]
      |=> !hot_reset_trigger)
      else $error("Hot trigger fired on a zero write");

   // Bus answers, refusals and unmapped places
   a_write_answer: assert property (
      do_write
      |=> s_axi_bvalid)
      else $error("Write response not raised after write");
   a_aw_refused: assert property (
      s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("Write channel ready while response pending");
   a_read_answer: assert property (
      ar_take
      |=> s_axi_rvalid && !s_axi_arready)
      else $error("Read answer not raised after address");
   a_rvalid_hold: assert property (
      s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("Read answer changed before taken");
   a_unmapped_read: assert property (
      ar_take && rd_sel == SSCR_REG_NONE
      |=> s_axi_rresp == SSCR_RESP_SLVERR && s_axi_rdata == 32'h00000000)
      else $error("Unmapped read not refused");
   a_unmapped_write: assert property (
      do_write && wr_sel == SSCR_REG_NONE && !fund_reset_active
      |=> s_axi_bresp == SSCR_RESP_SLVERR && $stable(marker_r) && $stable(base_spec_mode))
      else $error("Unmapped write not refused");
endmodule : sscr_regs

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import sscr_pkg::*;

   logic                   clock, rstn, fund, m_unl;
   logic [SSCR_ADDR_W-1:0] awaddr, araddr;
   logic [31:0]            wdata, rdata, seed, d, nv;
   logic [3:0]             wstrb, straps, m_mark, m_strap;
   logic [2:0]             lock, m_lock;
   logic [1:0]             bresp, rresp, mode, m_mode;
   logic                   awvalid, awready, wvalid, wready, bvalid, bready;
   logic                   arvalid, arready, rvalid, rready, ftrig, htrig, unlock;
   logic [3:0]             exp_w[$];
   logic [36:0]            exp_r[$];
   int                     n_errors, samples_checked, cycles;

   sscr_regs u_sscr_regs (
      .clock(clock), .rstn(rstn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready),
      .upstream_common_clock_strap(straps[0]), .master_mgmt_slow_strap(straps[1]),
      .refclk_mode_strap(straps[2]), .reset_halt_strap(straps[3]),
      .fund_reset_active(fund), .upstream_lock_state(lock),
      .fundamental_reset_trigger(ftrig), .hot_reset_trigger(htrig),
      .base_spec_mode(mode), .register_write_unlock(unlock)
   );

   // Free-running 125 MHz clock
   initial
   begin
      clock = 1'h0;
      forever #4 clock = ~clock;
   end

   // Xorshift source for stimulus values
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Expected status word from the model fields
   function logic [31:0] st();
      return {m_mark, 5'h00, m_lock, 8'h00, m_mode, m_strap, 6'h00};
   endfunction : st

   // Verdict and end of run
   task summarize();
      if (n_errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize

   // Write: expected {bresp, fundamental pulse, hot pulse} queued first
   task automatic wr(input logic [11:0] a, input logic [31:0] dd, input logic [3:0] s,
                     input logic [3:0] e);
      logic ad, wd;
      ad = 1'h0;
      wd = 1'h0;
      exp_w.push_back(e);
      awaddr  <= a;
      wdata   <= dd;
      wstrb   <= s;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      while (!(ad && wd))
      begin
         @(posedge clock);
         if (!ad && awready)
         begin
            ad = 1'h1;
            awvalid <= 1'h0;
         end
         if (!wd && wready)
         begin
            wd = 1'h1;
            wvalid <= 1'h0;
         end
      end
      do @(posedge clock); while (!bvalid);
      bready <= 1'h0;
      @(posedge clock);
   endtask : wr

   // Read: expected {unlock, mode, rresp, rdata} queued first
   task automatic rd(input logic [11:0] a, input logic [31:0] dd, input logic [1:0] r);
      exp_r.push_back({m_unl, m_mode, r, dd});
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      do @(posedge clock); while (!arready);
      arvalid <= 1'h0;
      do @(posedge clock); while (!rvalid);
      rready <= 1'h0;
      @(posedge clock);
   endtask : rd

   task automatic chk_w(input logic [3:0] got);
      logic [3:0] e;
      e = (exp_w.size() > 0) ? exp_w.pop_front() : 4'hx;
      samples_checked++;
      if (got !== e)
      begin
         n_errors++;
         $display("BAD %0t write result got %h exp %h", $time, got, e);
      end
   endtask : chk_w

   task automatic chk_r(input logic [36:0] got);
      logic [36:0] e;
      e = (exp_r.size() > 0) ? exp_r.pop_front() : 37'hx;
      samples_checked++;
      if (got !== e)
      begin
         n_errors++;
         $display("BAD %0t read result got %h exp %h", $time, got, e);
      end
   endtask : chk_r

   // Watches responses, compares against oldest note, cuts hangs short
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         summarize();
      end
      else
      begin
         if (bvalid && bready)
            chk_w({bresp, ftrig, htrig});
         if (rvalid && rready)
            chk_r({unlock, mode, rresp, rdata});
      end
   end

   // Main sequence
   initial
   begin
      seed = 32'h0000f167;
      rstn = 1'h0;
      fund = 1'h0;
      lock = 3'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = '0;
      araddr = '0;
      wdata = 32'h0;
      wstrb = 4'h0;
      d = rnd();
      straps = d[3:0];
      repeat (2) @(posedge clock);
      rstn <= 1'h1;
      repeat (6) @(posedge clock);
      m_mark = 4'h0;
      m_mode = SSCR_MODE_RST;
      m_lock = 3'h0;
      m_strap = straps;
      m_unl = 1'h0;
      rd(SSCR_STATUS_OFS, st(), SSCR_RESP_OKAY);
      rd(SSCR_CONTROL_OFS, 32'h0, SSCR_RESP_OKAY);
      // Locked: only the scratch field takes the random word
      d = rnd();
      wr(SSCR_STATUS_OFS, d, 4'hf, 4'h0);
      m_mark = d[31:28];
      rd(SSCR_STATUS_OFS, st(), SSCR_RESP_OKAY);
      wr(SSCR_CONTROL_OFS, 32'h8, 4'h1, 4'h0);
      m_unl = 1'h1;
      rd(SSCR_CONTROL_OFS, 32'h8, SSCR_RESP_OKAY);
      // Unlocked: every mode code is stored
      for (int i = 0; i < 4; i++)
      begin
         d = rnd();
         d[11:10] = i[1:0];
         wr(SSCR_STATUS_OFS, d, 4'hf, 4'h0);
         m_mark = d[31:28];
         m_mode = i[1:0];
         rd(SSCR_STATUS_OFS, st(), SSCR_RESP_OKAY);
      end
      // Trigger pulses for every combination, read back as zero
      for (int i = 0; i < 4; i++)
      begin
         wr(SSCR_CONTROL_OFS, 32'h8 | i, 4'h1, {2'h0, i[0], i[1]});
         rd(SSCR_CONTROL_OFS, 32'h8, SSCR_RESP_OKAY);
      end
      rd(SSCR_STATUS_OFS, st(), SSCR_RESP_OKAY);
      // All lock codes pass to the status word
      for (int i = 0; i < 8; i++)
      begin
         lock <= i[2:0];
         repeat (2) @(posedge clock);
         m_lock = i[2:0];
         rd(SSCR_STATUS_OFS, st(), SSCR_RESP_OKAY);
      end
      // Unmapped and unaligned places
      wr(12'h408, rnd(), 4'hf, {SSCR_RESP_SLVERR, 2'h0});
      rd(12'h408, 32'h0, SSCR_RESP_SLVERR);
      rd(12'h401, 32'h0, SSCR_RESP_SLVERR);
      // Fundamental reset recaptures pins and clears scratch, mode, unlock
      nv = rnd();
      straps <= ~m_strap;
      repeat (3) @(posedge clock);
      fund <= 1'h1;
      repeat (3) @(posedge clock);
      fund <= 1'h0;
      repeat (2) @(posedge clock);
      m_mark = 4'h0;
      m_mode = SSCR_MODE_RST;
      m_strap = ~m_strap;
      m_unl = 1'h0;
      rd(SSCR_STATUS_OFS, st(), SSCR_RESP_OKAY);
      rd(SSCR_CONTROL_OFS, 32'h0, SSCR_RESP_OKAY);
      nv[11:10] = 2'h2;
      wr(SSCR_STATUS_OFS, nv, 4'hf, 4'h0);
      m_mark = nv[31:28];
      rd(SSCR_STATUS_OFS, st(), SSCR_RESP_OKAY);
      repeat (4) @(posedge clock);
      summarize();
   end

endmodule : tb_top
